// ==== src/imwf_top.sv ====
// imwf_top: audio serial bus master with host slave port and two fifos.
// assumes the interconnect maps host byte address bits 3..2 onto adr_i.

// imwf_fifo: show-ahead fifo, valid/ready on both sides, sync clear
module imwf_fifo #(
    parameter int W = 24,
    parameter int D = 32
) (
    input  wire logic                 sys_clk,
    input  wire logic                 srst,
    input  wire logic                 clr,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic [W-1:0]         in_data,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [W-1:0]              out_data,
    output logic [$clog2(D):0]        count
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    wire          do_wr = in_valid & in_ready & ~clr;
    wire          do_rd = out_valid & out_ready & ~clr;
    // occupancy flags
    assign count     = wr_ptr - rd_ptr;
    assign in_ready  = count != (AW + 1)'(D);
    assign out_valid = count != '0;
    assign out_data  = mem[rd_ptr[AW-1:0]];
    // pointers
    always_ff @(posedge sys_clk) begin
        if (srst || clr) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + (AW + 1)'(do_wr);
            rd_ptr <= rd_ptr + (AW + 1)'(do_rd);
        end
    end
    // storage
    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule // imwf_fifo

module imwf_top
    import imwf_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        stb_i,
    input  wire logic        cyc_i,
    input  wire logic        we_i,
    input  wire logic [1:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             sck,
    output logic             ws,
    output logic             sdo,
    input  wire logic        sdi,
    output logic             aux_oversample_clock
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;
    logic [7:0]        ctrl_pre;
    logic [7:0]        ctrl_wm;
    logic [14:8]       mode_hi;
    logic [5:0]        mode_ww;
    logic              sdi_m;
    logic              sdi_s;
    logic [7:0]        pre_cnt;
    logic [7:0]        k;
    logic [23:0]       txsh;
    logic [23:0]       rxsh;
    logic [23:0]       hist_l;
    logic [23:0]       hist_r;
    logic              tx_in_ready;
    logic              tx_out_valid;
    logic [23:0]       tx_out_data;
    logic [CW-1:0]     tx_cnt;
    logic              rx_in_ready;
    logic              rx_out_valid;
    logic [23:0]       rx_out_data;
    logic [CW-1:0]     rx_cnt;
    imwf_width_t       wsel;
    logic [4:0]        nbits;
    logic [4:0]        cap_b;

    // host cycle decode; a full transmit fifo holds off the ack
    wire take    = stb_i & cyc_i & ~ack_o;
    wire wr_data = take & we_i & (adr_i == ADR_DATA);
    wire accept  = take & ~(wr_data & ~tx_in_ready);
    wire wr_reg  = accept & we_i;
    wire rx_pop  = accept & ~we_i & (adr_i == ADR_DATA);
    wire txen    = mode_hi[MODE_TXEN];
    wire rxen    = mode_hi[MODE_RXEN];
    // width decode, illegal codes fall back to 16-bit
    assign wsel  = (mode_ww == WW_20) ? IMWF_W20 :
                   (mode_ww == WW_24) ? IMWF_W24 :
                   (mode_ww == WW_32) ? IMWF_W32 : IMWF_W16;
    assign nbits = (wsel == IMWF_W16) ? SCK_N16 :
                   (wsel == IMWF_W20) ? SCK_N20 : SCK_N24;
    assign cap_b = (wsel == IMWF_W16) ? CAP_B16 : CAP_BWIDE;
    // write slice into the transmit fifo
    wire [23:0] tx_wdata = (wsel == IMWF_W32) ? dat_i[31:8]
                                              : dat_i[23:0];
    // receive entry returned with sign extension or padding
    wire [23:0] r = rx_out_data;
    wire [31:0] rx_rd = (wsel == IMWF_W16) ? {{16{r[15]}}, r[15:0]} :
                        (wsel == IMWF_W20) ? {{12{r[19]}}, r[19:0]} :
                        (wsel == IMWF_W24) ? {{8{r[23]}}, r} :
                                             {r, 8'h00};

    // status and read mux
    wire [7:0] status = {{2'h0, rx_cnt} > ctrl_wm, ~rx_in_ready,
                         ~rx_out_valid, ~ws, {2'h0, tx_cnt} < ctrl_wm,
                         ~tx_in_ready, ~tx_out_valid, ws};
    wire [31:0] rd_mux = (adr_i == ADR_CONTROL) ? {16'h0, ctrl_wm, ctrl_pre} :
                         (adr_i == ADR_MODE) ? {17'h0, mode_hi, 2'h0, mode_ww} :
                         (adr_i == ADR_STATUS) ? {24'h0, status} : rx_rd;

    // host port: one-cycle ack, registers and read data
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_o    <= 1'b0;
            dat_o    <= 32'h0000_0000;
            ctrl_pre <= PRE_RST;
            ctrl_wm  <= WM_RST;
            mode_hi  <= 7'h00;
            mode_ww  <= WW_RST;
        end else begin
            ack_o <= accept;
            if (accept && !we_i) begin
                dat_o <= rd_mux;
            end
            if (wr_reg && adr_i == ADR_CONTROL) begin
                ctrl_pre <= dat_i[PRE_LSB +: 8];
                ctrl_wm  <= dat_i[WM_LSB +: 8];
            end
            if (wr_reg && adr_i == ADR_MODE) begin
                mode_hi <= dat_i[14:8];
                mode_ww <= dat_i[5:0];
            end
        end
    end

    // serial input synchroniser
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sdi_m <= 1'b0;
            sdi_s <= 1'b0;
        end else begin
            sdi_m <= sdi;
            sdi_s <= sdi_m;
        end
    end

    // prescaler tick; 256 ticks make one channel word, 512 one sample
    wire        tick = pre_cnt == ctrl_pre;
    wire [12:0] prod = {5'h00, k} * {8'h00, nbits};
    wire [7:0]  frac = prod[7:0];
    wire [4:0]  bidx = prod[12:8];
    wire        rise = tick & (frac < {3'h0, nbits});

    // clock generation
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pre_cnt              <= 8'h00;
            k                    <= 8'h00;
            aux_oversample_clock <= 1'b0;
            sck                  <= 1'b0;
            ws                   <= 1'b0;
        end else begin
            pre_cnt <= tick ? 8'h00 : pre_cnt + 8'h01;
            k       <= k + {7'h00, tick};
            aux_oversample_clock <= aux_oversample_clock ^ tick;
            if (tick) begin
                sck <= frac < 8'h80;
            end
            if (rise && bidx == 5'h00) begin
                ws <= ~ws;
            end
        end
    end

    // transmit: load one bit after the word select flip
    wire        tx_load = rise & (bidx == 5'h01);
    wire        tx_rep  = mode_hi[MODE_MO] & ws;
    wire        tx_pop  = tx_load & txen & ~tx_rep & tx_out_valid;
    wire [23:0] tx_word = tx_rep ? hist_l :
                          tx_out_valid ? tx_out_data :
                          ws ? hist_r : hist_l;
    wire [23:0] tx_al = (wsel == IMWF_W16) ? {tx_word[15:0], 8'h00} :
                        (wsel == IMWF_W20) ? {tx_word[19:0], 4'h0} :
                                             tx_word;
    wire [23:0] next_txsh = tx_load ? tx_al : {txsh[22:0], 1'b0};

    // transmit shifter, last-sample history, serial out
    always_ff @(posedge sys_clk) begin
        if (srst || !txen) begin
            txsh   <= 24'h00_0000;
            sdo    <= 1'b0;
            hist_l <= 24'h00_0000;
            hist_r <= 24'h00_0000;
        end else if (rise) begin
            txsh <= next_txsh;
            sdo  <= next_txsh[23];
            if (tx_load && ws) begin
                hist_r <= tx_word;
            end
            if (tx_load && !ws) begin
                hist_l <= tx_word;
            end
        end
    end

    // receive: sample each rising edge, capture after the lsb
    wire [23:0] next_rxsh = {rxsh[22:0], sdi_s};
    wire        rx_ch   = (cap_b == 5'h00) ? ws : ~ws;
    wire        rx_push = rise & rxen & (bidx == cap_b) &
                          (~mode_hi[MODE_MI] | (rx_ch == mode_hi[MODE_SLR]));
    wire [23:0] rx_in = (wsel == IMWF_W16) ? {8'h00, next_rxsh[15:0]} :
                        (wsel == IMWF_W20) ? {4'h0, next_rxsh[19:0]} :
                                             next_rxsh;

    // receive shifter
    always_ff @(posedge sys_clk) begin
        if (srst || !rxen) begin
            rxsh <= 24'h00_0000;
        end else if (rise) begin
            rxsh <= next_rxsh;
        end
    end

    // buffers, cleared while their direction is disabled
    imwf_fifo #(.W(FIFO_DW), .D(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .clr       (~txen),
        .in_valid  (wr_data),
        .in_ready  (tx_in_ready),
        .in_data   (tx_wdata),
        .out_valid (tx_out_valid),
        .out_ready (tx_pop),
        .out_data  (tx_out_data),
        .count     (tx_cnt)
    );
    imwf_fifo #(.W(FIFO_DW), .D(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .clr       (~rxen),
        .in_valid  (rx_push),
        .in_ready  (rx_in_ready),
        .in_data   (rx_in),
        .out_valid (rx_out_valid),
        .out_ready (rx_pop),
        .out_data  (rx_out_data),
        .count     (rx_cnt)
    );

    // checking helpers: rising edges seen in the current word
    logic [4:0] rise_cnt;
    logic       seen_half;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rise_cnt  <= 5'h00;
            seen_half <= 1'b0;
        end else if (rise) begin
            rise_cnt  <= (bidx == 5'h00) ? 5'h01 : rise_cnt + 5'h01;
            seen_half <= seen_half | (bidx == 5'h00);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_wr_take;
        take && we_i && adr_i == ADR_DATA && tx_in_ready;
    endsequence
    sequence s_ack_pulse;
        ack_o ##1 !ack_o;
    endsequence

    tx_write_ack_a: assert property (s_wr_take |=> s_ack_pulse)
        else $error("data write not acked for one cycle");
    ack_cause_a: assert property (ack_o |-> $past(stb_i && cyc_i))
        else $error("ack without strobe and cycle");
    ack_end_a: assert property (ack_o |=> !ack_o)
        else $error("ack held past one cycle");
    mode_write_a: assert property (
        take && we_i && adr_i == ADR_MODE |=> mode_ww == $past(dat_i[5:0]))
        else $error("width code not stored");
    ws_rate_a: assert property ($changed(ws) |-> $past(tick && k == 8'h00))
        else $error("word select moved off the word boundary");
    aux_rate_a: assert property ($changed(aux_oversample_clock)
        |-> $past(tick)) else $error("aux clock moved off a tick");
    pre_div_a: assert property (
        tick && ctrl_pre == 8'h03 && !take |=> !tick [*3] ##1 tick)
        else $error("prescaler spacing wrong");
    sck_count_a: assert property (
        rise && bidx == 5'h00 && seen_half |-> rise_cnt == nbits)
        else $error("bit clock count per word wrong");
    tx_align16_a: assert property (
        tx_load && txen && wsel == IMWF_W16 |=> txsh[7:0] == 8'h00)
        else $error("16-bit word not msb aligned");
    rd_sign16_a: assert property (
        ack_o && $past(rx_pop) && $past(wsel == IMWF_W16)
        |-> dat_o[31:16] == {16{dat_o[15]}})
        else $error("16-bit read not sign extended");
    rd_pad32_a: assert property (
        ack_o && $past(rx_pop) && $past(wsel == IMWF_W32)
        |-> dat_o[7:0] == 8'h00) else $error("32-bit read not padded");
    sdo_idle_a: assert property (!txen ##1 !txen |-> !sdo)
        else $error("serial out active while disabled");
endmodule // imwf_top

// ==== include/imwf_pkg.sv ====
// imwf_pkg: constants and types shared by the audio serial master.
// assumes one 125 MHz system clock and a 2-bit word-addressed host port.
package imwf_pkg;
    // host register word addresses
    localparam logic [1:0]  ADR_CONTROL = 2'h0;
    localparam logic [1:0]  ADR_MODE    = 2'h1;
    localparam logic [1:0]  ADR_STATUS  = 2'h2;
    localparam logic [1:0]  ADR_DATA    = 2'h3;
    // reset values
    localparam logic [7:0]  PRE_RST     = 8'h00;
    localparam logic [7:0]  WM_RST      = 8'h00;
    localparam logic [5:0]  WW_RST      = 6'h00;
    // control and mode field positions
    localparam int          PRE_LSB     = 0;
    localparam int          WM_LSB      = 8;
    localparam int          MODE_MO     = 8;
    localparam int          MODE_MI     = 9;
    localparam int          MODE_SLR    = 10;
    localparam int          MODE_TXEN   = 11;
    localparam int          MODE_RXEN   = 12;
    localparam int          MODE_TXIE   = 13;
    localparam int          MODE_RXIE   = 14;
    // word width codes
    localparam logic [5:0]  WW_16       = 6'h10;
    localparam logic [5:0]  WW_20       = 6'h14;
    localparam logic [5:0]  WW_24       = 6'h18;
    localparam logic [5:0]  WW_32       = 6'h20;
    // bit clock periods per word slot, and receive capture bit
    localparam logic [4:0]  SCK_N16     = 5'h10;
    localparam logic [4:0]  SCK_N20     = 5'h15;
    localparam logic [4:0]  SCK_N24     = 5'h19;
    localparam logic [4:0]  CAP_B16     = 5'h01;
    localparam logic [4:0]  CAP_BWIDE   = 5'h00;
    // buffers
    localparam int          FIFO_DW     = 24;
    localparam int          FIFO_DEPTH  = 32;
    typedef enum logic [1:0] {IMWF_W16, IMWF_W20, IMWF_W24, IMWF_W32}
        imwf_width_t;
endpackage

// ==== verif/imwf_codec.sv ====
// imwf_codec: behavioural audio codec on the far side of the serial link.
// assumes sck and ws come from the master and sdo changes on rising sck.
module imwf_codec (
    input  wire logic       sck,
    input  wire logic       ws,
    input  wire logic       sdo,
    input  wire logic [5:0] w_bits,
    output logic            sdi
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] PAT = 24'h9A5C3E;
    logic [31:0] sr;
    logic        ws_seen;
    int          p;
    logic [31:0] words [$];

    // idle until the first word boundary is seen
    initial begin
        sdi = 1'b0;
        sr = 32'h0;
        ws_seen = 1'b0;
        p = 40;
    end

    // one slot per falling sck: take sdo, drive the next sdi bit
    always @(negedge sck) begin : slot_b
        int pos;
        sr = {sr[30:0], sdo};
        if (p < 40) p = p + 1;
        pos = p;
        if (pos == int'(w_bits)) begin
            words.push_back(sr & ((32'h1 << w_bits) - 32'h1));
        end
        if (pos >= 1 && pos <= int'(w_bits)) begin
            sdi <= PAT[24 - pos];
        end else begin
            sdi <= ~sdi; // gap slot: no kind value
        end
        if (ws !== ws_seen) begin
            ws_seen = ws;
            p = 0;
        end
    end
endmodule // imwf_codec

// ==== verif/i2s_master_word_format_tb.sv ====
// i2s_master_word_format_tb: self-checking bench for the serial master.
// assumes imwf_codec on the serial side; this module is the host.
module i2s_master_word_format_tb import imwf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [5:0]  code;
        logic [7:0]  pre;
        int          n;
        logic [5:0]  wb;
        logic [31:0] rx;
        logic [31:0] t0;
        logic [31:0] t1;
    } imwf_row_t;
    logic        sys_clk, srst, stb_i, cyc_i, we_i, sdi, hit;
    logic        ack_o, sck, ws, sdo, aux;
    logic [1:0]  adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [5:0]  wbits;
    int          failures, n_compared, lat, sck_n, aux_n, cyc_n, n;
    imwf_row_t   rows [4];
    logic [1:0]  regs [3] = '{ADR_STATUS, ADR_CONTROL, ADR_MODE};
    // status: both fifos empty, word select already on the right channel
    logic [31:0] rexp [3] = '{32'h23, 32'h0000FFFF, 32'h00007F3F};

    imwf_top dut_u (.sys_clk(sys_clk), .srst(srst), .stb_i(stb_i),
        .cyc_i(cyc_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .sck(sck), .ws(ws), .sdo(sdo),
        .sdi(sdi), .aux_oversample_clock(aux));
    imwf_codec codec_u (.sck(sck), .ws(ws), .sdo(sdo), .w_bits(wbits),
        .sdi(sdi));

    // compare and count
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic stop_test;
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one host access, held until acknowledged, then released
    task automatic xfer(input logic w, input logic [1:0] a,
                        input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        adr_i = a;
        dat_i = d;
        we_i = w;
        {stb_i, cyc_i} = 2'b11;
        lat = 0;
        do begin
            @(posedge sys_clk);
            lat++;
        end while (ack_o !== 1'b1 && lat < 9000);
        rd = dat_o;
        chk("ack wait", {31'h0, lat < 9000}, 32'h1);
        #1;
        {stb_i, cyc_i} = 2'b00;
        chk("ack release", {31'h0, ack_o}, 32'h0);
    endtask

    // reset held for k cycles, outputs checked while held
    task automatic rst(input int k);
        @(posedge sys_clk);
        #1;
        srst = 1'b1;
        repeat (k) @(posedge sys_clk);
        #1;
        chk("reset outputs", {27'h0, ack_o, sck, ws, sdo, aux}, 32'h0);
        srst = 1'b0;
    endtask

    // wait k word-select changes, counting cycles, sck rises, aux toggles
    task automatic run_ws(input int k);
        logic wl, sp, ap;
        {wl, sp, ap} = {ws, sck, aux};
        sck_n = 0;
        aux_n = 0;
        cyc_n = 0;
        while (k > 0 && cyc_n < 20000) begin
            @(posedge sys_clk);
            cyc_n++;
            sck_n += int'(sck && !sp);
            aux_n += int'(aux !== ap);
            if (ws !== wl) k--;
            {wl, sp, ap} = {ws, sck, aux};
        end
        chk("ws wait", {31'h0, k == 0}, 32'h1);
    endtask

    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // watchdog against a hung handshake
    initial begin
        repeat (80000) @(posedge sys_clk);
        failures++;
        stop_test;
    end

    // main sequence
    initial begin
        {srst, stb_i, cyc_i, we_i} = 4'b1000;
        adr_i = 2'h0;
        dat_i = 32'h0;
        wbits = 6'd16;
        rows = '{
          '{WW_16, 8'h00, 16, 6'd16, 32'hFFFF9A5C, 32'hC5D1, 32'h7081},
          '{WW_20, 8'h01, 21, 6'd20, 32'hFFF9A5C3, 32'h3C5D1, 32'hF7081},
          '{WW_24, 8'h03, 25, 6'd24, 32'hFF9A5C3E, 32'hB3C5D1, 32'h6F7081},
          '{WW_32, 8'h00, 25, 6'd24, 32'h9A5C3E00, 32'hA7B3C5, 32'h5E6F70}};
        rst(20);
        for (int i = 0; i < 3; i++) begin
            xfer(1'b1, regs[i], 32'hFFFFFFFF);
            chk("write ack latency", lat, 2);
            xfer(1'b0, regs[i], 32'h0);
            chk("register readback", rd, rexp[i]);
        end
        foreach (rows[i]) begin
            rst(2);
            wbits = rows[i].wb;
            xfer(1'b1, ADR_CONTROL, {24'h0, rows[i].pre});
            xfer(1'b1, ADR_MODE, {19'h0, 2'b11, 5'h0, rows[i].code});
            run_ws(2);
            run_ws(2);
            chk("ws period", cyc_n, 512 * (rows[i].pre + 1));
            chk("sck rises", sck_n, 2 * rows[i].n);
            chk("aux toggles", aux_n, 512);
            codec_u.words.delete();
            xfer(1'b1, ADR_DATA, 32'hA7B3C5D1);
            xfer(1'b1, ADR_DATA, 32'h5E6F7081);
            run_ws(6);
            hit = 1'b0;
            for (int j = 0; j + 1 < codec_u.words.size(); j++) begin
                hit |= codec_u.words[j] === rows[i].t0 &&
                       codec_u.words[j + 1] === rows[i].t1;
            end
            chk("serial words sent", hit, 1);
            xfer(1'b0, ADR_DATA, 32'h0);
            xfer(1'b0, ADR_DATA, 32'h0);
            chk("received word", rd, rows[i].rx);
        end
        // transmit fifo filled until the status full flag sets, then the ack is held back
        rst(2);
        xfer(1'b1, ADR_MODE, {20'h0, 1'b1, 5'h0, WW_16});
        n = 0;
        do begin
            xfer(1'b1, ADR_DATA, 32'(n));
            xfer(1'b0, ADR_STATUS, 32'h0);
            n++;
        end while (rd[2] !== 1'b1 && n < 40);
        chk("tx full flag", {31'h0, rd[2]}, 32'h1);
        chk("fifo depth", {31'h0, n >= FIFO_DEPTH && n <= FIFO_DEPTH + 1},
            32'h1);
        xfer(1'b1, ADR_DATA, 32'h0);
        chk("ack held while full", {31'h0, lat > 2}, 32'h1);
        xfer(1'b1, ADR_MODE, 32'h0);
        xfer(1'b0, ADR_STATUS, 32'h0);
        chk("fifos cleared", rd & 32'hEE, 32'h22);
        stop_test;
    end
endmodule // i2s_master_word_format_tb
